//--- hdl/mmdf_pkg.sv
// Package for the meter menu and display filter block.
// Holds register offsets, parameter indices, reset values and timing counts.
// Assumes a single 250 MHz system clock.
package mmdf_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_KHZ = 250000;        // 250 MHz expressed in kHz
  localparam int HOLD_MS = 2000;          // Select hold for program entry
  localparam int SCROLL_MS = 4000;        // Auto scroll interval
  localparam int ALT_MS = 1000;           // Alternating display phase
  localparam int REPEAT_MS = 250;         // Reset button auto-repeat period
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam int SCROLL_CYC = SCROLL_MS * CLK_KHZ;
  localparam int ALT_CYC = ALT_MS * CLK_KHZ;
  localparam int REPEAT_CYC = REPEAT_MS * CLK_KHZ;

  // ---------------------------------------------------------------------
  // Parameter indices inside the input module
  // ---------------------------------------------------------------------
  localparam int NPRM = 9;
  localparam logic [3:0] P_DP = 4'h0;     // Decimal point setting, 0..4
  localparam logic [3:0] P_OFS = 4'h1;    // Display offset
  localparam logic [3:0] P_FLT = 4'h2;    // Filter level, 0..3
  localparam logic [3:0] P_BAND = 4'h3;   // Filter band
  localparam logic [3:0] P_STY = 4'h4;    // 0 keyed, 1 live-signal style
  localparam logic [3:0] P_INP1 = 4'h5;
  localparam logic [3:0] P_DSP1 = 4'h6;
  localparam logic [3:0] P_INP2 = 4'h7;
  localparam logic [3:0] P_DSP2 = 4'h8;
  localparam logic [31:0] DP_CHOICES = 32'h0000_0005;
  localparam logic [31:0] FLT_CHOICES = 32'h0000_0004;
  localparam logic [31:0] STY_CHOICES = 32'h0000_0002;
  localparam logic [31:0] OFS_LIMIT = 32'h0000_4E1F; // 19999

  // Reset values of the parameters
  localparam logic [31:0] RST_INP2 = 32'h0000_2710;  // 10000
  localparam logic [31:0] RST_DSP2 = 32'h0000_2710;
  localparam logic [31:0] RST_BAND = 32'h0000_000A;
  localparam logic [31:0] RST_FLT = 32'h0000_0001;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] A_PRM0 = 8'h00;  // Parameters at A_PRM0 + 4*index
  localparam logic [7:0] A_CTRL = 8'h24;  // Bit0 scroll enable, bit1 code lock
  localparam logic [7:0] A_STAT = 8'h28;  // Menu and display state
  localparam logic [7:0] A_DISP = 8'h2C;  // Filtered display value
  localparam int CTRL_SCROLL = 0;
  localparam int CTRL_LOCK = 1;

  // Menu states
  typedef enum logic [2:0] {
    MMDF_DISP,
    MMDF_TOP,
    MMDF_PAR,
    MMDF_DIG,
    MMDF_LIVE
  } mmdf_state_e;

endpackage

//--- hdl/mmdf_top.sv
// Front panel menu, display selection and display processing of a meter.
// Buttons and the hardware lock are asynchronous pins; all other inputs
// come from logic on clk_sys.
//
// How it works
// - Select held two seconds in display mode enters programming mode.
// - Select press in display mode advances input, minimum, maximum display.
// - Scroll enabled steps the display automatically every four seconds.
// - Indicators one and two follow the active setpoint outputs.
// - Parameter writes are refused while in display mode.
// - Programming entry is refused under code lock or hardware lock.
// - Top level alternates prompt and module; reset cycles, select enters.
// - Select moves to next parameter leaving passed parameters unchanged.
// - After the last parameter the menu returns to top showing exit.
// - Parameter view alternates name and value; reset steps the selection.
// - Select stores the shown choice, applies it, advances.
// - First reset on a numeric parameter opens rightmost digit flashing.
// - Reset increments active digit; holding reset repeats the increment.
// - Short select moves digit; held select accepts value and advances.
// - Select on exit commits changes to memory and returns to display.
// - Signed offset within 19999 is added; zero action rewrites it.
// - Filter mixes input with previous display at 1, 1/4, 1/8, 1/16.
// - Filter bypassed while change exceeds band, engaged again below it.
// - Band compared in display units; zero band keeps filter engaged.
// - Decimal point applies to displays, scaling display values, setpoints.
// - Live style shows stored input; reset shows live input; select captures.
// - Keyed style input values take decimal position of input range.
// - Display is linear map of two points, extrapolated beyond them.
//
// Chosen here: strobed register access and the register offsets.
module mmdf_top
  import mmdf_pkg::*;
#(
  parameter int HOLD_N = HOLD_CYC,
  parameter int SCROLL_N = SCROLL_CYC,
  parameter int ALT_N = ALT_CYC,
  parameter int REPEAT_N = REPEAT_CYC
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic sel_btn_n,
  input wire logic rst_btn_n,
  input wire logic hw_lock,
  input wire logic sp1_active,
  input wire logic sp2_active,
  input wire logic min_enable,
  input wire logic max_enable,
  input wire logic signed [31:0] min_value,
  input wire logic signed [31:0] max_value,
  input wire logic [2:0] range_dp,
  input wire logic sample_valid,
  input wire logic signed [31:0] sample_in,
  input wire logic zero_req,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic prog_mode,
  output logic [2:0] menu_state,
  output logic [3:0] param_index,
  output logic module_shown,
  output logic alt_phase,
  output logic [1:0] disp_select,
  output logic signed [31:0] shown_value,
  output logic [2:0] shown_dp,
  output logic [2:0] flash_digit,
  output logic ind1,
  output logic ind2,
  output logic nv_commit,
  output logic signed [31:0] display_value
);

  generate
    if (HOLD_N < 2 || SCROLL_N < 2 || ALT_N < 2 || REPEAT_N < 2)
    begin : g_bad
      $error("mmdf_top: timing counts must be at least 2");
    end
  endgenerate

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic sel_m, sel_s, sel_p, rst_m, rst_s, rst_p, hwl_m, hwl_s;
    logic consumed;
    logic [31:0] shold;
    logic [31:0] rcnt;
    logic [31:0] scnt;
    logic [31:0] acnt;
    mmdf_state_e st;
    logic alt;
    logic mod_sel;
    logic [3:0] pidx;
    logic [31:0] edit;
    logic [19:0] bcd;
    logic [2:0] dig;
    logic [1:0] dsel;
    logic [NPRM-1:0][31:0] prm;
    logic scroll_en;
    logic code_lock;
    logic seeded;
    logic [31:0] scaled;
    logic [31:0] disp;
    logic [31:0] shown;
    logic [2:0] sdp;
    logic ind1, ind2, commit, prog;
    logic [31:0] rdata;
  } mmdf_state_s;

  mmdf_state_s q, d;

  // -----------------------------------------------------------------------
  // Functions
  // -----------------------------------------------------------------------
  // Number of choices of a selection parameter, zero for numeric ones
  function automatic logic [31:0] choices(input logic [3:0] idx);
    logic [31:0] n;
    n = 32'h0;
    if (idx == P_DP) n = DP_CHOICES;
    else if (idx == P_FLT) n = FLT_CHOICES;
    else if (idx == P_STY) n = STY_CHOICES;
    return n;
  endfunction

  // Magnitude to five BCD digits by shift and add-three
  function automatic logic [19:0] to_bcd(input logic [31:0] v);
    logic [19:0] b;
    logic [16:0] m;
    b = 20'h0;
    m = v[16:0];
    for (int i = 16; i >= 0; i--)
    begin
      for (int k = 0; k < 5; k++)
        if (b[4*k +: 4] > 4'h4) b[4*k +: 4] = b[4*k +: 4] + 4'h3;
      b = {b[18:0], m[i]};
    end
    return b;
  endfunction

  function automatic logic [31:0] from_bcd(input logic [19:0] b);
    logic [31:0] v;
    v = 32'h0;
    for (int k = 4; k >= 0; k--)
      v = (v * 32'h0000_000A) + {28'h0, b[4*k +: 4]};
    return v;
  endfunction

  function automatic logic [31:0] iabs(input logic signed [31:0] v);
    return (v < 0) ? -v : v;
  endfunction

  // Two-point linear map, extrapolated with the same slope
  function automatic logic signed [31:0] scale_map(input logic signed [31:0] x,
    input logic [NPRM-1:0][31:0] p);
    logic signed [47:0] num;
    logic signed [47:0] den;
    logic signed [47:0] r;
    den = 48'(signed'(p[P_INP2])) - 48'(signed'(p[P_INP1]));
    num = (48'(x) - 48'(signed'(p[P_INP1])))
      * (48'(signed'(p[P_DSP2])) - 48'(signed'(p[P_DSP1])));
    r = (den == 48'sh0) ? 48'sh0 : num / den;
    return 32'(r + 48'(signed'(p[P_DSP1])));
  endfunction

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb
  begin
    logic sel_press, sel_rel_short, sel_hold, rst_press, rst_rep;
    logic locked, prog, adv, wr_ok;
    logic [31:0] ch, sum, nxt, mag, dlt;
    logic signed [31:0] s, diff, ofs;
    logic [3:0] nib;
    d = q;
    sel_press = 1'b0;
    sel_rel_short = 1'b0;
    sel_hold = 1'b0;
    rst_press = 1'b0;
    rst_rep = 1'b0;
    locked = 1'b0;
    prog = 1'b0;
    adv = 1'b0;
    wr_ok = 1'b0;
    ch = 32'h0;
    sum = 32'h0;
    nxt = 32'h0;
    mag = 32'h0;
    dlt = 32'h0;
    s = 32'sh0;
    diff = 32'sh0;
    ofs = 32'sh0;
    nib = 4'h0;

    // Pin synchronisers, buttons active low
    d.sel_m = ~sel_btn_n;
    d.sel_s = q.sel_m;
    d.sel_p = q.sel_s;
    d.rst_m = ~rst_btn_n;
    d.rst_s = q.rst_m;
    d.rst_p = q.rst_s;
    d.hwl_m = hw_lock;
    d.hwl_s = q.hwl_m;

    // Select press, short release and hold detection
    sel_press = q.sel_s & ~q.sel_p;
    d.shold = q.sel_s ? ((q.shold == 32'(HOLD_N)) ? q.shold : q.shold + 32'h1) : 32'h0;
    sel_hold = q.sel_s && (q.shold == 32'(HOLD_N - 1));
    sel_rel_short = ~q.sel_s & q.sel_p & ~q.consumed;
    if (sel_press)
      d.consumed = 1'b0;
    if (sel_hold)
      d.consumed = 1'b1;

    // Reset press and auto-repeat while held
    rst_press = q.rst_s & ~q.rst_p;
    rst_rep = q.rst_s && (q.rcnt == 32'(REPEAT_N - 1));
    d.rcnt = (q.rst_s && !rst_rep) ? q.rcnt + 32'h1 : 32'h0;

    // Alternating display phase
    d.acnt = (q.acnt == 32'(ALT_N - 1)) ? 32'h0 : q.acnt + 32'h1;
    if (q.acnt == 32'(ALT_N - 1))
      d.alt = ~q.alt;

    locked = q.code_lock | q.hwl_s;
    d.commit = 1'b0;
    ch = choices(q.pidx);

    // Menu state machine
    case (q.st)
      MMDF_DISP:
      begin
        if (sel_hold && !locked)
        begin
          d.st = MMDF_TOP;
          d.mod_sel = 1'b1;
        end
        else if (sel_rel_short || (q.scroll_en && q.scnt == 32'(SCROLL_N - 1)))
          adv = 1'b1;
      end
      MMDF_TOP:
      begin
        if (rst_press)
          d.mod_sel = ~q.mod_sel;
        else if (sel_press && !q.mod_sel)
        begin
          d.st = MMDF_DISP;
          d.commit = 1'b1;
        end
        else if (sel_press)
        begin
          d.st = MMDF_PAR;
          d.pidx = P_DP;
          d.edit = q.prm[P_DP];
        end
      end
      MMDF_PAR:
      begin
        if (sel_press)
        begin
          d.prm[q.pidx] = q.edit;
          if (q.pidx == 4'(NPRM - 1))
          begin
            d.st = MMDF_TOP;
            d.mod_sel = 1'b0;
          end
          else
          begin
            d.pidx = q.pidx + 4'h1;
            d.edit = q.prm[q.pidx + 4'h1];
          end
        end
        else if (rst_press && ch != 32'h0)
          d.edit = (q.edit + 32'h1 >= ch) ? 32'h0 : q.edit + 32'h1;
        else if (rst_press && q.prm[P_STY][0]
          && (q.pidx == P_INP1 || q.pidx == P_INP2))
          d.st = MMDF_LIVE;
        else if (rst_press)
        begin
          d.st = MMDF_DIG;
          d.bcd = to_bcd(iabs(q.edit));
          d.dig = 3'h0;
        end
      end
      MMDF_LIVE:
      begin
        d.edit = sample_in;
        if (sel_press)
        begin
          d.prm[q.pidx] = sample_in;
          d.st = MMDF_PAR;
          d.pidx = q.pidx + 4'h1;
          d.edit = q.prm[q.pidx + 4'h1];
        end
      end
      MMDF_DIG:
      begin
        if (rst_press || rst_rep)
        begin
          nib = q.bcd[4*q.dig +: 4];
          d.bcd[4*q.dig +: 4] = (nib == 4'h9) ? 4'h0 : nib + 4'h1;
        end
        if (sel_hold)
        begin
          mag = from_bcd(q.bcd);
          d.prm[q.pidx] = q.edit[31] ? -mag : mag;
          if (q.pidx == 4'(NPRM - 1))
          begin
            d.st = MMDF_TOP;
            d.mod_sel = 1'b0;
          end
          else
          begin
            d.st = MMDF_PAR;
            d.pidx = q.pidx + 4'h1;
            d.edit = q.prm[q.pidx + 4'h1];
          end
        end
        else if (sel_rel_short)
          d.dig = (q.dig == 3'h4) ? 3'h0 : q.dig + 3'h1;
      end
      default:
        d.st = MMDF_DISP;
    endcase

    // Display selection among enabled values
    d.scnt = (q.st != MMDF_DISP || adv || !q.scroll_en) ? 32'h0 : q.scnt + 32'h1;
    if (adv)
    begin
      nxt = {30'h0, q.dsel};
      for (int i = 0; i < 3; i++)
      begin
        nxt = (nxt == 32'h2) ? 32'h0 : nxt + 32'h1;
        if ((nxt == 32'h1 && !min_enable) || (nxt == 32'h2 && !max_enable))
          nxt = (nxt == 32'h2) ? 32'h0 : nxt + 32'h1;
        if (nxt == 32'h2 && !max_enable)
          nxt = 32'h0;
        break;
      end
      d.dsel = nxt[1:0];
    end

    // Register port: parameter writes only in programming mode
    prog = (q.st != MMDF_DISP);
    d.rdata = 32'h0;
    if (wr && addr == A_CTRL)
    begin
      d.scroll_en = wdata[CTRL_SCROLL];
      d.code_lock = wdata[CTRL_LOCK];
    end
    else if (wr && addr < A_CTRL && addr[1:0] == 2'b00)
    begin
      wr_ok = prog;
      if (wr_ok)
        d.prm[addr[5:2]] = wdata;
    end
    if (rd && addr == A_CTRL)
      d.rdata = {30'h0, q.code_lock, q.scroll_en};
    else if (rd && addr == A_STAT)
      d.rdata = {16'h0, q.hwl_s, q.dsel, q.mod_sel, q.pidx, 5'h0, q.st};
    else if (rd && addr == A_DISP)
      d.rdata = q.disp;
    else if (rd && addr < A_CTRL && addr[1:0] == 2'b00)
      d.rdata = q.prm[addr[5:2]];

    // Scaling, offset and adaptive filter once per update
    s = scale_map(sample_in, q.prm);
    if (sample_valid)
    begin
      d.scaled = s;
      ofs = signed'(q.prm[P_OFS]);
      sum = s + ofs;
      diff = signed'(sum) - signed'(q.disp);
      dlt = iabs(diff);
      if (!q.seeded || (q.prm[P_BAND] != 32'h0 && dlt > q.prm[P_BAND]))
        d.disp = sum;
      else
        d.disp = q.disp + 32'(diff >>> ((q.prm[P_FLT][1:0] == 2'h0) ? 0
          : 32'(q.prm[P_FLT][1:0]) + 32'h1));
      d.seeded = 1'b1;
    end

    // Zero action moves the offset to cancel the present reading
    if (zero_req)
    begin
      ofs = -signed'(q.scaled);
      if (ofs > signed'(OFS_LIMIT))
        ofs = signed'(OFS_LIMIT);
      if (ofs < -signed'(OFS_LIMIT))
        ofs = -signed'(OFS_LIMIT);
      d.prm[P_OFS] = ofs;
    end

    // Value shown and its decimal point
    d.sdp = q.prm[P_DP][2:0];
    if (q.st == MMDF_DISP)
      d.shown = (q.dsel == 2'h1) ? min_value : (q.dsel == 2'h2) ? max_value : q.disp;
    else if (q.st == MMDF_DIG)
      d.shown = from_bcd(q.bcd);
    else
      d.shown = q.edit;
    if (prog && (q.pidx == P_INP1 || q.pidx == P_INP2))
      d.sdp = range_dp;

    // Setpoint indicators
    d.ind1 = sp1_active;
    d.ind2 = sp2_active;

    // Programming mode flag kept in a flop
    d.prog = (d.st != MMDF_DISP);
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.st <= MMDF_DISP;
      q.prm[P_INP2] <= RST_INP2;
      q.prm[P_DSP2] <= RST_DSP2;
      q.prm[P_BAND] <= RST_BAND;
      q.prm[P_FLT] <= RST_FLT;
    end
    else if (clk_en)
      q <= d;
  end

  // Outputs straight from state flops
  assign rdata = q.rdata;
  assign prog_mode = q.prog;
  assign menu_state = q.st;
  assign param_index = q.pidx;
  assign module_shown = q.mod_sel;
  assign alt_phase = q.alt;
  assign disp_select = q.dsel;
  assign shown_value = q.shown;
  assign shown_dp = q.sdp;
  assign flash_digit = q.dig;
  assign ind1 = q.ind1;
  assign ind2 = q.ind2;
  assign nv_commit = q.commit;
  assign display_value = q.disp;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst || !clk_en);

  sequence s_hold_unlocked;
    q.st == MMDF_DISP && q.sel_s && q.shold == 32'(HOLD_N - 1)
      && !q.code_lock && !q.hwl_s;
  endsequence

  chk_hold_entry: assert property (s_hold_unlocked |=> q.st == MMDF_TOP)
    else $error("hold did not enter programming");
  chk_lock_refuse: assert property (q.st == MMDF_DISP
    && (q.code_lock || q.hwl_s) |=> q.st == MMDF_DISP)
    else $error("locked meter entered programming");
  chk_write_reject: assert property (q.st == MMDF_DISP && wr
    && addr < A_CTRL && !zero_req |=> q.prm == $past(q.prm))
    else $error("parameter changed in display mode");
  chk_ind_follow: assert property (##1 ind1 == $past(sp1_active)
    && ind2 == $past(sp2_active))
    else $error("setpoint indicator mismatch");
  chk_exit_commit: assert property (q.st == MMDF_TOP && !q.mod_sel
    && q.sel_s && !q.sel_p && !(q.rst_s && !q.rst_p) |=> nv_commit && q.st == MMDF_DISP)
    else $error("exit did not commit");
  chk_last_param: assert property (q.st == MMDF_PAR && q.pidx == 4'(NPRM - 1)
    && q.sel_s && !q.sel_p |=> q.st == MMDF_TOP && !q.mod_sel)
    else $error("last parameter did not return to exit");
  chk_sel_store: assert property (q.st == MMDF_PAR && q.pidx == P_FLT
    && q.sel_s && !q.sel_p |=> q.prm[P_FLT] == $past(q.edit) && q.pidx == P_BAND)
    else $error("selection not stored");
  chk_num_open: assert property (q.st == MMDF_PAR && q.pidx == P_OFS
    && q.rst_s && !q.rst_p && !(q.sel_s && !q.sel_p) |=> q.st == MMDF_DIG ##0 q.dig == 3'h0)
    else $error("numeric edit not opened at rightmost digit");
  chk_seed_first: assert property (!q.seeded && sample_valid
    |=> display_value == $past(q.prm[P_OFS]) + $past(scale_map(sample_in, q.prm)))
    else $error("filter not seeded by first reading");

endmodule

//--- sim/mmdf_operator.sv
// Operator model for the front panel: presses select and reset buttons.
// Assumes buttons idle high and read low while pressed, sampled on clk_sys.
module mmdf_operator (
  input wire logic clk_sys,
  output logic sel_btn_n,
  output logic rst_btn_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // Button drive
  // ---------------------------------------------------------------------
  // Both buttons start released
  initial
  begin
    sel_btn_n = 1'b1;
    rst_btn_n = 1'b1;
  end

  // Press one button for a number of cycles, release, let the menu settle
  task automatic press(input logic which, input int cyc);
    @(posedge clk_sys);
    if (which)
      rst_btn_n <= 1'b0;
    else
      sel_btn_n <= 1'b0;
    repeat (cyc) @(posedge clk_sys);
    rst_btn_n <= 1'b1;
    sel_btn_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

//--- sim/test_mmdf_top.sv
// Self-checking testbench for the meter menu and display filter block.
// Assumes short timing parameters and the operator model on the buttons.
module test_mmdf_top
  import mmdf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------
  localparam int SCR = 40;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic sel_btn_n;
  logic rst_btn_n;
  logic hw_lock = 1'b0;
  logic sp1_active = 1'b0;
  logic sp2_active = 1'b0;
  logic sample_valid = 1'b0;
  logic signed [31:0] sample_in = 32'h0;
  logic zero_req = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clk_en = 1'b1;
  logic min_enable = 1'b1;
  logic max_enable = 1'b1;
  logic [2:0] range_dp = 3'h3;
  logic alt_phase;
  logic alt_seen;
  logic signed [31:0] shown_value;
  logic [2:0] shown_dp;
  logic [31:0] rdata;
  logic prog_mode;
  logic [2:0] menu_state;
  logic [3:0] param_index;
  logic module_shown;
  logic [1:0] disp_select;
  logic [2:0] flash_digit;
  logic ind1;
  logic ind2;
  logic nv_commit;
  logic signed [31:0] display_value;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  logic [31:0] rst_tab [NPRM] = '{32'h0, 32'h0, RST_FLT, RST_BAND, 32'h0, 32'h0, 32'h0,
    RST_INP2, RST_DSP2};

  mmdf_operator i_op (.clk_sys(clk_sys), .sel_btn_n(sel_btn_n), .rst_btn_n(rst_btn_n));

  mmdf_top #(.HOLD_N(20), .SCROLL_N(SCR), .ALT_N(8), .REPEAT_N(6)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .sel_btn_n(sel_btn_n),
    .rst_btn_n(rst_btn_n), .hw_lock(hw_lock), .sp1_active(sp1_active),
    .sp2_active(sp2_active), .min_enable(min_enable), .max_enable(max_enable),
    .min_value(32'sh0000_0005), .max_value(32'sh0000_0009), .range_dp(range_dp),
    .sample_valid(sample_valid), .sample_in(sample_in), .zero_req(zero_req),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .prog_mode(prog_mode),
    .menu_state(menu_state), .param_index(param_index), .module_shown(module_shown),
    .alt_phase(alt_phase), .disp_select(disp_select), .shown_value(shown_value),
    .shown_dp(shown_dp),
    .flash_digit(flash_digit), .ind1(ind1), .ind2(ind2), .nv_commit(nv_commit),
    .display_value(display_value));

  // Free running system clock
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compare one value
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // One cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // One cycle read strobe, data checked in the following cycle
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 check("rdata", rdata, exp);
  endtask

  // Bounded wait for a menu state
  task automatic wait_state(input logic [2:0] st);
    n = 0;
    while (menu_state !== st && n < 100)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    check("menu_state", {29'h0, menu_state}, {29'h0, st});
    if (menu_state !== st)
      finish_test();
  endtask

  // Cycles until the shown display changes
  task automatic wait_disp();
    logic [1:0] v;
    v = disp_select;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    while (disp_select === v && n < 200);
  endtask

  // One new reading and the resulting display
  task automatic sample(input logic signed [31:0] v, input logic signed [31:0] exp);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    sample_in <= v;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    #1 check("display_value", display_value, exp);
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < NPRM; i++)
      rd_reg(8'(4 * i), rst_tab[i]);
    rd_reg(8'hFC, 32'h0);
    wr_reg(A_PRM0 + 8'h04, 32'h0000_0005);
    rd_reg(A_PRM0 + 8'h04, 32'h0);
    // Setpoint indicators follow one cycle later
    for (int i = 1; i < 4; i++)
    begin
      @(posedge clk_sys);
      sp1_active <= i[0];
      sp2_active <= i[1];
      @(posedge clk_sys);
      #1 check("ind", {30'h0, ind2, ind1}, 32'(i));
    end
    // Alternating phase flips every eight cycles and freezes without enable
    @(posedge clk_sys);
    #1 alt_seen = alt_phase;
    repeat (8) @(posedge clk_sys);
    #1 check("alt_phase", {31'h0, alt_phase}, {31'h0, ~alt_seen});
    @(posedge clk_sys);
    clk_en <= 1'b0;
    #1 alt_seen = alt_phase;
    repeat (8) @(posedge clk_sys);
    clk_en <= 1'b1;
    #1 check("alt_phase", {31'h0, alt_phase}, {31'h0, alt_seen});
    // Manual display stepping and automatic scrolling
    for (int i = 1; i < 4; i++)
    begin
      i_op.press(1'b0, 4);
      check("disp_select", {30'h0, disp_select}, 32'(i % 3));
      check("shown_value", shown_value, (i == 1) ? 32'h5 : (i == 2) ? 32'h9 : 32'h0);
    end
    // Disabled minimum display is skipped
    min_enable <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      i_op.press(1'b0, 4);
      check("disp_select", {30'h0, disp_select}, 32'(2 - 2 * i));
    end
    min_enable <= 1'b1;
    wr_reg(A_CTRL, 32'h0000_0001);
    wait_disp();
    wait_disp();
    check("scroll", 32'(n), 32'(SCR));
    // Entry refused under code lock, then under hardware lock
    wr_reg(A_CTRL, 32'h0000_0002);
    i_op.press(1'b0, 30);
    check("prog_mode", {31'h0, prog_mode}, 32'h0);
    wr_reg(A_CTRL, 32'h0);
    hw_lock <= 1'b1;
    i_op.press(1'b0, 30);
    check("prog_mode", {31'h0, prog_mode}, 32'h0);
    hw_lock <= 1'b0;
    i_op.press(1'b0, 30);
    wait_state(3'h1);
    check("module_shown", {31'h0, module_shown}, 32'h1);
    i_op.press(1'b1, 4);
    check("module_shown", {31'h0, module_shown}, 32'h0);
    i_op.press(1'b1, 4);
    i_op.press(1'b0, 4);
    wait_state(3'h2);
    check("param_index", {28'h0, param_index}, 32'h0);
    // Decimal point selection stepped twice and stored
    i_op.press(1'b1, 4);
    i_op.press(1'b1, 4);
    check("shown_value", shown_value, 32'h2);
    i_op.press(1'b0, 4);
    rd_reg(A_PRM0, 32'h0000_0002);
    // Offset edited digit by digit to 11
    i_op.press(1'b1, 4);
    wait_state(3'h3);
    check("flash_digit", {29'h0, flash_digit}, 32'h0);
    i_op.press(1'b1, 4);
    i_op.press(1'b0, 4);
    check("flash_digit", {29'h0, flash_digit}, 32'h1);
    i_op.press(1'b1, 4);
    i_op.press(1'b0, 30);
    wait_state(3'h2);
    check("param_index", {28'h0, param_index}, 32'h2);
    rd_reg(A_PRM0 + 8'h04, 32'd11);
    rd_reg(A_PRM0, 32'h0000_0002);
    // Style set to live signal; first input value captured from sample_in
    for (int i = 2; i < NPRM; i++)
    begin
      if (i == 4)
        i_op.press(1'b1, 4);
      i_op.press(1'b0, 4);
      if (i == 4)
      begin
        check("shown_dp", {29'h0, shown_dp}, 32'h3);
        i_op.press(1'b1, 4);
        sample_in <= 32'sd7;
        repeat (4) @(posedge clk_sys);
        check("menu_state", {29'h0, menu_state}, 32'h4);
        check("shown_value", shown_value, 32'h7);
      end
    end
    wait_state(3'h1);
    check("module_shown", {31'h0, module_shown}, 32'h0);
    rd_reg(A_PRM0 + 8'h14, 32'h7);
    wr_reg(A_PRM0 + 8'h14, 32'h0);
    rd_reg(A_PRM0 + 8'h14, 32'h0);
    // Exit commits to memory
    fork
      i_op.press(1'b0, 4);
      begin
        n = 0;
        while (nv_commit !== 1'b1 && n < 40)
        begin
          @(posedge clk_sys);
          #1 n++;
        end
      end
    join
    check("nv_commit", 32'(n < 40), 32'h1);
    wait_state(3'h0);
    check("shown_dp", {29'h0, shown_dp}, 32'h2);
    // Seed, filtered step, bypass and extrapolation with offset 11
    sample(32'sd100, 32'sd111);
    sample(32'sd108, 32'sd113);
    sample(32'sd1000, 32'sd1011);
    sample(32'sd20000, 32'sd20011);
    @(posedge clk_sys);
    zero_req <= 1'b1;
    @(posedge clk_sys);
    zero_req <= 1'b0;
    rd_reg(A_PRM0 + 8'h04, -32'sd19999);
    finish_test();
  end
endmodule
